// >>> design/rcw_pkg.sv
// Shared constants, register map and types for the run control block
package rcw_pkg;

  // Clock and time bases
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned TIME_RES_NS    = 800;
  localparam int unsigned REAL_UPD_US    = 500;
  localparam int unsigned LIVE_UPD_MS    = 10;
  localparam int unsigned TICK_CYC       = (TIME_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REAL_UPD_CYC   = (REAL_UPD_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned LIVE_UPD_CYC   = (LIVE_UPD_MS * 1000000) / CLK_PERIOD_NS;

  // Widths and window map
  localparam int unsigned ENERGY_W       = 16;
  localparam int unsigned CNT_W          = 32;
  localparam int unsigned NWIN_DEF       = 8;
  localparam int unsigned NWIN_MAX       = 16;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL       = 12'h000;
  localparam logic [11:0] OFS_CFG        = 12'h004;
  localparam logic [11:0] OFS_PRESET     = 12'h008;
  localparam logic [11:0] OFS_STATUS     = 12'h00C;
  localparam logic [11:0] OFS_REALTIME   = 12'h010;
  localparam logic [11:0] OFS_LIVETIME   = 12'h014;
  localparam logic [11:0] OFS_BINNED     = 12'h018;
  localparam logic [11:0] OFS_TRIGS      = 12'h01C;
  localparam logic [11:0] OFS_WIN_NUM    = 12'h020;
  localparam logic [3:0]  WIN_PAGE       = 4'h1;
  localparam logic [1:0]  WIN_FLD_LOW    = 2'h0;
  localparam logic [1:0]  WIN_FLD_HIGH   = 2'h1;
  localparam logic [1:0]  WIN_FLD_TOTAL  = 2'h2;

  // Control bits
  localparam int unsigned CTRL_START     = 0;
  localparam int unsigned CTRL_STOP      = 1;
  localparam int unsigned CTRL_RESUME    = 2;

  // Reset values
  localparam logic [8:0]  CFG_RST        = 9'h000;
  localparam logic [31:0] PRESET_RST     = 32'h0000_0000;

  // Preset selection
  typedef enum logic [2:0] {
    RCW_PRE_NONE, RCW_PRE_REAL, RCW_PRE_LIVE, RCW_PRE_BINNED, RCW_PRE_TRIG
  } rcw_preset_t;

  // Configuration fields, bit 0 upward: mode, gate, sync
  typedef struct packed {
    logic        xseg_src;
    logic        xseg_en;
    logic        seg_master;
    logic        bp_sync_en;
    logic        gate_pol;
    logic        gate_en;
    rcw_preset_t mode;
  } rcw_cfg_t;

  // One processed event from the pulse processor
  typedef struct packed {
    logic                valid;
    logic                binned;
    logic                trigger;
    logic [ENERGY_W-1:0] energy;
  } rcw_event_t;

endpackage

// >>> design/rcw_time_acc.sv
// Exact elapsed-time accumulator with a coarse periodic published copy
`timescale 1ns/1ps
`default_nettype none
module rcw_time_acc #(
  parameter int unsigned TICK = 80,
  parameter int unsigned UPD  = 50000,
  parameter int unsigned W    = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clear,
  input  wire logic         enable,
  input  wire logic         running,
  input  wire logic         finish,
  output logic [W-1:0]      exact,
  output logic [W-1:0]      shown
);
  localparam int unsigned PW = (TICK > 1) ? $clog2(TICK) : 1;
  localparam int unsigned UW = (UPD > 1) ? $clog2(UPD) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK - 1);
  localparam logic [UW-1:0] UPD_LAST = UW'(UPD - 1);

  logic [PW-1:0] pre_reg;
  logic [UW-1:0] upd_reg;
  logic [W-1:0]  exact_next;
  wire           tick     = enable && (pre_reg == PRE_LAST);
  wire           upd_due  = running && (upd_reg == UPD_LAST);

  assign exact_next = tick ? exact + W'(1) : exact;

  // Fine count in resolution units; the copy only moves on interval, at end or on clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= '0;
      upd_reg <= '0;
      exact   <= '0;
      shown   <= '0;
    end else if (clear) begin
      pre_reg <= '0;
      upd_reg <= '0;
      exact   <= '0;
      shown   <= '0;
    end else begin
      pre_reg <= enable ? (tick ? '0 : pre_reg + PW'(1)) : pre_reg;
      upd_reg <= running ? (upd_due ? '0 : upd_reg + UW'(1)) : '0;
      exact   <= exact_next;
      if (finish || upd_due) begin
        shown <= exact_next;
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/rcw_win_cnt.sv
// One energy window: inclusive bound compare and event total
`timescale 1ns/1ps
`default_nettype none
module rcw_win_cnt #(
  parameter int unsigned EW = 16,
  parameter int unsigned CW = 32
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          clear,
  input  wire logic          count_en,
  input  wire logic [EW-1:0] energy,
  input  wire logic [EW-1:0] low,
  input  wire logic [EW-1:0] high,
  output logic [CW-1:0]      total
);
  // Both bounds inclusive
  wire in_window = (energy >= low) && (energy <= high);

  // Total is kept until a fresh run clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      total <= '0;
    end else if (clear) begin
      total <= '0;
    end else if (count_en && in_window) begin
      total <= total + CW'(1);
    end
  end
endmodule
`default_nettype wire

// >>> design/rcw_run_ctrl.sv
// Run control: presets, start sync, gate, resume and energy window totals
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module rcw_run_ctrl #(
  parameter int unsigned NWIN         = rcw_pkg::NWIN_DEF,
  parameter int unsigned REAL_UPD_CYC = rcw_pkg::REAL_UPD_CYC,
  parameter int unsigned LIVE_UPD_CYC = rcw_pkg::LIVE_UPD_CYC
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire rcw_pkg::rcw_event_t evt,
  input  wire logic                live_in,
  input  wire logic                gate_pin,
  input  wire logic                trig_line_in,
  output logic                     trig_line_out,
  output logic                     trig_line_oe,
  input  wire logic                fp_sync_in,
  output logic                     fp_sync_out,
  output logic                     fp_sync_oe,
  output logic                     acq_enable,
  output logic                     spectrum_clear,
  output logic                     run_active
);
  localparam int unsigned EW = rcw_pkg::ENERGY_W;
  localparam int unsigned CW = rcw_pkg::CNT_W;
  localparam int unsigned NW = $clog2(NWIN + 1);

  typedef enum logic [1:0] {RCW_IDLE, RCW_ARMED, RCW_RUN} rcw_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // Registers and state

  rcw_state_t        state_reg;
  rcw_state_t        state_next;
  rcw_pkg::rcw_cfg_t cfg_reg;
  logic [31:0]       preset_reg;
  logic [NW-1:0]     win_num_reg;
  logic [EW-1:0]     win_lo_reg [NWIN];
  logic [EW-1:0]     win_hi_reg [NWIN];
  logic              resume_reg;
  logic              preset_done_reg;
  logic              clear_pulse_reg;
  logic [CW-1:0]     binned_reg;
  logic [CW-1:0]     trigs_reg;
  logic [2:0]        sync1_reg;
  logic [2:0]        sync2_reg;
  logic              trig_prev_reg;
  logic [31:0]       prdata_reg;
  logic              pslverr_reg;

  logic [CW-1:0]     real_exact;
  logic [CW-1:0]     real_shown;
  logic [CW-1:0]     live_exact;
  logic [CW-1:0]     live_shown;
  logic [CW-1:0]     win_total [NWIN];

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: gate, backplane line, front panel sync

  // Three pins each pass two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg     <= 3'h7;
      sync2_reg     <= 3'h7;
      trig_prev_reg <= 1'b1;
    end else begin
      sync1_reg     <= {fp_sync_in, trig_line_in, gate_pin};
      sync2_reg     <= sync1_reg;
      trig_prev_reg <= sync2_reg[1];
    end
  end

  wire gate_s   = sync2_reg[0];
  wire trig_s   = sync2_reg[1];
  wire fp_s     = sync2_reg[2];
  // Active-low shared line: a falling edge is the common start instant
  wire trig_go  = trig_prev_reg && !trig_s;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire        bus_setup  = psel && !penable;
  wire        bus_wr     = psel && penable && pwrite;
  wire [3:0]  win_idx    = paddr[7:4];
  wire [1:0]  win_fld    = paddr[3:2];
  wire        win_page   = (paddr[11:8] == rcw_pkg::WIN_PAGE) && (32'(win_idx) < NWIN);
  wire        win_wr     = bus_wr && win_page;
  wire        hit_ctrl   = paddr == rcw_pkg::OFS_CTRL;
  wire        hit_cfg    = paddr == rcw_pkg::OFS_CFG;
  wire        hit_preset = paddr == rcw_pkg::OFS_PRESET;
  wire        hit_winnum = paddr == rcw_pkg::OFS_WIN_NUM;
  wire        start_cmd  = bus_wr && hit_ctrl && pwdata[rcw_pkg::CTRL_START];
  wire        stop_cmd   = bus_wr && hit_ctrl && pwdata[rcw_pkg::CTRL_STOP];

  //////////////////////////////////////////////////////////////////////////////
  // Preset comparison and acquisition qualifiers

  logic preset_met;
  always_comb begin
    case (cfg_reg.mode)
      rcw_pkg::RCW_PRE_NONE:   preset_met = 1'b0;
      rcw_pkg::RCW_PRE_REAL:   preset_met = real_exact >= preset_reg;
      rcw_pkg::RCW_PRE_LIVE:   preset_met = live_exact >= preset_reg;
      rcw_pkg::RCW_PRE_BINNED: preset_met = binned_reg >= preset_reg;
      rcw_pkg::RCW_PRE_TRIG:   preset_met = trigs_reg >= preset_reg;
      default:                 preset_met = 1'b0;
    endcase
  end

  wire running    = state_reg == RCW_RUN;
  wire preset_hit = running && preset_met;
  wire inhibit    = cfg_reg.gate_en && (gate_s == cfg_reg.gate_pol);
  // Counting freezes in the very cycle a preset is reached
  wire acq        = running && !inhibit && !preset_hit && !stop_cmd;
  wire start_go   = !cfg_reg.bp_sync_en || trig_go;
  wire run_start  = (state_reg == RCW_ARMED) && start_go && !stop_cmd;
  wire fresh      = run_start && !resume_reg;
  wire run_end    = running && (stop_cmd || preset_hit);
  wire ev_take    = acq && evt.valid;

  //////////////////////////////////////////////////////////////////////////////
  // Run state machine

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RCW_IDLE: begin
        if (start_cmd && !stop_cmd) begin
          state_next = RCW_ARMED;
        end
      end
      RCW_ARMED: begin
        if (stop_cmd) begin
          state_next = RCW_IDLE;
        end else if (start_go) begin
          state_next = RCW_RUN;
        end
      end
      RCW_RUN: begin
        if (run_end) begin
          state_next = RCW_IDLE;
        end
      end
      default: state_next = RCW_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= RCW_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Start sync drivers

  // Master pulls the segment line once armed; with cross-segment sync it
  // waits for the front panel, so all segments fall in the same instant
  wire master_go = cfg_reg.xseg_en ? !fp_s : 1'b1;
  assign trig_line_out = 1'b0;
  assign trig_line_oe  = cfg_reg.bp_sync_en && cfg_reg.seg_master
                         && (state_reg == RCW_ARMED) && master_go;
  // The source master repeats its own arming onto the front panel
  assign fp_sync_out   = 1'b0;
  assign fp_sync_oe    = cfg_reg.xseg_en && cfg_reg.seg_master && cfg_reg.xseg_src
                         && (state_reg == RCW_ARMED);

  //////////////////////////////////////////////////////////////////////////////
  // Control registers written by software

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg     <= rcw_pkg::rcw_cfg_t'(rcw_pkg::CFG_RST);
      preset_reg  <= rcw_pkg::PRESET_RST;
      win_num_reg <= '0;
      resume_reg  <= 1'b0;
    end else if (bus_wr) begin
      if (hit_cfg) begin
        cfg_reg <= rcw_pkg::rcw_cfg_t'(pwdata[8:0]);
      end
      if (hit_preset) begin
        preset_reg <= pwdata;
      end
      // Count above the built-in windows saturates
      if (hit_winnum) begin
        win_num_reg <= (pwdata > 32'(NWIN)) ? NW'(NWIN) : pwdata[NW-1:0];
      end
      if (start_cmd && state_reg == RCW_IDLE) begin
        resume_reg <= pwdata[rcw_pkg::CTRL_RESUME];
      end
    end
  end

  // Window bounds held per entry
  for (genvar g = 0; g < NWIN; g++) begin : g_win
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        win_lo_reg[g] <= '0;
        win_hi_reg[g] <= '0;
      end else if (win_wr && 32'(win_idx) == g) begin
        if (win_fld == rcw_pkg::WIN_FLD_LOW) begin
          win_lo_reg[g] <= pwdata[EW-1:0];
        end
        if (win_fld == rcw_pkg::WIN_FLD_HIGH) begin
          win_hi_reg[g] <= pwdata[EW-1:0];
        end
      end
    end

    // Only the first win_num windows take part
    rcw_win_cnt #(
      .EW (EW),
      .CW (CW)
    ) u_win (
      .clk      (pclk),
      .rst_n    (presetn),
      .clear    (fresh),
      .count_en (ev_take && evt.binned && (32'(win_num_reg) > g)),
      .energy   (evt.energy),
      .low      (win_lo_reg[g]),
      .high     (win_hi_reg[g]),
      .total    (win_total[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Run statistics

  // Event counts restart only on a fresh start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      binned_reg      <= '0;
      trigs_reg       <= '0;
      preset_done_reg <= 1'b0;
      clear_pulse_reg <= 1'b0;
    end else begin
      clear_pulse_reg <= fresh;
      if (fresh) begin
        binned_reg <= '0;
        trigs_reg  <= '0;
      end else begin
        if (ev_take && evt.binned) begin
          binned_reg <= binned_reg + CW'(1);
        end
        if (acq && evt.trigger) begin
          trigs_reg <= trigs_reg + CW'(1);
        end
      end
      if (run_start) begin
        preset_done_reg <= 1'b0;
      end else if (preset_hit) begin
        preset_done_reg <= 1'b1;
      end
    end
  end

  rcw_time_acc #(
    .TICK (rcw_pkg::TICK_CYC),
    .UPD  (REAL_UPD_CYC),
    .W    (CW)
  ) u_real (
    .clk     (pclk),
    .rst_n   (presetn),
    .clear   (fresh),
    .enable  (running && !preset_hit && !stop_cmd),
    .running (running),
    .finish  (run_end),
    .exact   (real_exact),
    .shown   (real_shown)
  );

  rcw_time_acc #(
    .TICK (rcw_pkg::TICK_CYC),
    .UPD  (LIVE_UPD_CYC),
    .W    (CW)
  ) u_live (
    .clk     (pclk),
    .rst_n   (presetn),
    .clear   (fresh),
    .enable  (acq && live_in),
    .running (running),
    .finish  (run_end),
    .exact   (live_exact),
    .shown   (live_shown)
  );

  //////////////////////////////////////////////////////////////////////////////
  // APB read path, captured in the setup cycle so data leaves a flop

  logic [31:0] rd_data;
  logic        rd_err;
  logic [31:0] win_word;

  always_comb begin
    win_word = '0;
    for (int i = 0; i < NWIN; i++) begin
      if (32'(win_idx) == i) begin
        case (win_fld)
          rcw_pkg::WIN_FLD_LOW:   win_word = 32'(win_lo_reg[i]);
          rcw_pkg::WIN_FLD_HIGH:  win_word = 32'(win_hi_reg[i]);
          rcw_pkg::WIN_FLD_TOTAL: win_word = 32'(win_total[i]);
          default:                win_word = '0;
        endcase
      end
    end
  end

  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    case (paddr)
      rcw_pkg::OFS_CTRL:     rd_data = '0;
      rcw_pkg::OFS_CFG:      rd_data = 32'(cfg_reg);
      rcw_pkg::OFS_PRESET:   rd_data = preset_reg;
      rcw_pkg::OFS_STATUS:   rd_data = {28'h0000000, inhibit, preset_done_reg,
                                        state_reg == RCW_ARMED, running};
      rcw_pkg::OFS_REALTIME: rd_data = real_shown;
      rcw_pkg::OFS_LIVETIME: rd_data = live_shown;
      rcw_pkg::OFS_BINNED:   rd_data = binned_reg;
      rcw_pkg::OFS_TRIGS:    rd_data = trigs_reg;
      rcw_pkg::OFS_WIN_NUM:  rd_data = 32'(win_num_reg);
      default: begin
        rd_data = win_page ? win_word : 32'h0000_0000;
        rd_err  = !(win_page && win_fld != 2'h3);
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (bus_setup) begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_data;
      pslverr_reg <= rd_err;
    end
  end

  // Zero wait states: every access completes in its first access cycle
  assign pready         = 1'b1;
  assign prdata         = prdata_reg;
  assign pslverr        = pslverr_reg && psel && penable;
  assign acq_enable     = acq;
  assign spectrum_clear = clear_pulse_reg;
  assign run_active     = running;
endmodule
`default_nettype wire

// >>> verification/rcw_monitor.sv
// Port-level concurrent checks for the run control block
`timescale 1ns/1ps
`default_nettype none
module rcw_monitor (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  input wire rcw_pkg::rcw_event_t evt,
  input wire logic                live_in,
  input wire logic                gate_pin,
  input wire logic                trig_line_in,
  input wire logic                trig_line_out,
  input wire logic                trig_line_oe,
  input wire logic                fp_sync_in,
  input wire logic                fp_sync_out,
  input wire logic                fp_sync_oe,
  input wire logic                acq_enable,
  input wire logic                spectrum_clear,
  input wire logic                run_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Stop command decode at the access edge
  wire stop_wr = psel && penable && pwrite && paddr == 12'h000 && pwdata[1];

  ////////////////////////////////////////////////////////////////////////////
  // Clear pulse only on entry to a run, one cycle wide
  property p_clr_entry;
    spectrum_clear |-> $rose(run_active) ##1 !spectrum_clear;
  endproperty
  a_clr_entry: assert property (p_clr_entry) else $error("clear pulse misplaced");
  // Counting never outside a run
  property p_acq_run;
    acq_enable |-> run_active;
  endproperty
  a_acq_run: assert property (p_acq_run) else $error("acquire outside run");
  // Stop excludes its own cycle, run ends next edge
  property p_stop;
    stop_wr && run_active |-> !acq_enable ##1 !run_active;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not honoured");
  // Any run end is preceded by a cycle with counting off
  property p_end;
    $fell(run_active) |-> !$past(acq_enable);
  endproperty
  a_end: assert property (p_end) else $error("run ended while counting");
  // Error response only in an access phase
  property p_err_phase;
    pslverr |-> psel && penable;
  endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
  // Hole in the map answers with error and zero
  sequence s_hole;
    psel && !penable && paddr inside {[12'h024:12'h0FC]} ##1 psel && penable;
  endsequence
  property p_hole;
    s_hole |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read accepted");
  // Line only ever pulled low, and only while waiting to start
  property p_line_od;
    trig_line_oe |-> !trig_line_out && !run_active;
  endproperty
  a_line_od: assert property (p_line_od) else $error("trigger line misdriven");
  // Front panel line is open drain too
  property p_fp_od;
    fp_sync_oe |-> !fp_sync_out;
  endproperty
  a_fp_od: assert property (p_fp_od) else $error("front panel misdriven");

  // Main scenarios reached
  c_clr: cover property (spectrum_clear);
  c_end: cover property ($fell(run_active));
  c_err: cover property (pslverr);
  c_line: cover property (trig_line_oe);
  c_fp: cover property (fp_sync_oe);
endmodule
`default_nettype wire

// >>> verification/rcw_peer_model.sv
// Peer module on the shared start lines, open drain with pull-ups
`timescale 1ns/1ps
`default_nettype none
module rcw_peer_model (
  input  wire logic pclk,
  input  wire logic dut_line_oe,
  input  wire logic dut_fp_oe,
  input  wire logic pulse_line,
  input  wire logic pulse_fp,
  output logic      line,
  output logic      fp_line
);
  logic [2:0] line_cnt = 3'h0;
  logic [2:0] fp_cnt   = 3'h0;

  // Pull held several cycles so the far synchronisers catch it
  always_ff @(posedge pclk) begin
    line_cnt <= pulse_line ? 3'h6 : (line_cnt != 3'h0) ? line_cnt - 3'h1 : 3'h0;
    fp_cnt   <= pulse_fp ? 3'h6 : (fp_cnt != 3'h0) ? fp_cnt - 3'h1 : 3'h0;
  end

  // Wired-AND: any puller wins, pull-up otherwise
  assign line    = !(dut_line_oe || line_cnt != 3'h0);
  assign fp_line = !(dut_fp_oe || fp_cnt != 3'h0);
endmodule
`default_nettype wire

// >>> verification/tb_rcw_run_ctrl.sv
// Self-checking bench for the run control block
`timescale 1ns/1ps
`default_nettype none
module tb_rcw_run_ctrl;
  logic                pclk, presetn, psel, penable, pwrite, live_in, gate_pin;
  logic                pready, pslverr, serr, lp, fpp, line, fline;
  logic                trig_line_out, trig_line_oe, fp_sync_out, fp_sync_oe;
  logic                acq_enable, spectrum_clear, run_active;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rdat;
  rcw_pkg::rcw_event_t evt;
  int                  err_count, checked, m;

  rcw_run_ctrl #(.REAL_UPD_CYC(20), .LIVE_UPD_CYC(50)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .evt(evt), .live_in(live_in), .gate_pin(gate_pin), .trig_line_in(line),
    .trig_line_out(trig_line_out), .trig_line_oe(trig_line_oe), .fp_sync_in(fline),
    .fp_sync_out(fp_sync_out), .fp_sync_oe(fp_sync_oe), .acq_enable(acq_enable),
    .spectrum_clear(spectrum_clear), .run_active(run_active));

  rcw_peer_model peer (.pclk(pclk), .dut_line_oe(trig_line_oe), .dut_fp_oe(fp_sync_oe),
    .pulse_line(lp), .pulse_fp(fpp), .line(line), .fp_line(fline));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task chk(input string s, input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask

  // One APB transfer; held until pready at an access edge
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One processed event, trigger always flagged
  task ev(input logic [15:0] e, input logic b);
    @(posedge pclk);
    evt <= {1'b1, b, 1'b1, e};
    @(posedge pclk);
    evt <= '0;
  endtask

  // Poll the running flag, bounded
  task waitrun(input logic v);
    for (int i = 0; i < 600; i++) begin
      bus(1'b0, 12'h00C, 32'h0);
      if (rdat[0] === v) break;
    end
    chk("running", {31'h0, rdat[0]}, {31'h0, v});
  endtask

  task end_of_test;
    $display("Checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Hang guard, well beyond the expected run length
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    end_of_test;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
    pwdata = 32'h0; evt = '0; live_in = 1'b0; gate_pin = 1'b0; lp = 1'b0; fpp = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Two windows, boundary energies, one unbinned event
    bus(1'b1, 12'h020, 32'h2); bus(1'b1, 12'h100, 32'h100); bus(1'b1, 12'h104, 32'h200);
    bus(1'b1, 12'h110, 32'h300); bus(1'b1, 12'h114, 32'h300); bus(1'b1, 12'h140, 32'h55);
    bus(1'b1, 12'h000, 32'h1);
    waitrun(1'b1);
    ev(16'h0FF, 1'b1); ev(16'h100, 1'b1); ev(16'h200, 1'b1); ev(16'h201, 1'b1);
    ev(16'h300, 1'b1); ev(16'h2FF, 1'b1); ev(16'h150, 1'b0);
    repeat (300) @(posedge pclk);
    bus(1'b0, 12'h00C, 32'h0);
    chk("no preset run", rdat[0], 1'b1);
    bus(1'b1, 12'h000, 32'h2);
    waitrun(1'b0);
    bus(1'b0, 12'h108, 32'h0);
    chk("window 0", rdat, 32'h2);
    bus(1'b0, 12'h118, 32'h0);
    chk("window 1", rdat, 32'h1);
    bus(1'b0, 12'h10C, 32'h0);
    chk("hole err", serr, 1'b1);
    bus(1'b0, 12'h040, 32'h0);
    chk("gap err", serr, 1'b1);
    chk("gap data", rdat, 32'h0);
    $display("test windows done");
    // Resume keeps totals, fresh start clears, gate inhibits
    bus(1'b1, 12'h000, 32'h5);
    waitrun(1'b1);
    ev(16'h180, 1'b1);
    bus(1'b1, 12'h000, 32'h2);
    waitrun(1'b0);
    bus(1'b0, 12'h108, 32'h0);
    chk("resumed", rdat, 32'h3);
    bus(1'b1, 12'h004, 32'h18);
    gate_pin <= 1'b1;
    bus(1'b1, 12'h000, 32'h1);
    waitrun(1'b1);
    bus(1'b0, 12'h108, 32'h0);
    chk("cleared", rdat, 32'h0);
    bus(1'b0, 12'h00C, 32'h0);
    chk("inhibit", rdat[3], 1'b1);
    ev(16'h180, 1'b1);
    gate_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    ev(16'h190, 1'b1);
    bus(1'b1, 12'h000, 32'h2);
    waitrun(1'b0);
    bus(1'b0, 12'h108, 32'h0);
    chk("gated", rdat, 32'h1);
    $display("test resume and gate done");
    // Every preset kind, value 3, exact count at end
    live_in <= 1'b1;
    for (m = 1; m <= 4; m++) begin
      bus(1'b1, 12'h004, m);
      bus(1'b1, 12'h008, 32'h3);
      bus(1'b1, 12'h000, 32'h1);
      waitrun(1'b1);
      ev(16'h010, 1'b1); ev(16'h020, 1'b1);
      bus(1'b0, 12'h00C, 32'h0);
      chk("before preset", rdat[0], 1'b1);
      ev(16'h030, 1'b1);
      waitrun(1'b0);
      bus(1'b0, 12'h00C, 32'h0);
      chk("preset done", rdat[2], 1'b1);
      bus(1'b0, 12'h00C + 12'(4 * m), 32'h0);
      chk("final count", rdat, 32'h3);
    end
    $display("test presets done");
    // Start sync: master, follower, cross-segment master
    bus(1'b1, 12'h004, 32'h60);
    bus(1'b1, 12'h000, 32'h1);
    waitrun(1'b1);
    bus(1'b1, 12'h000, 32'h2);
    for (m = 0; m < 3; m++) begin
      bus(1'b1, 12'h004, m == 2 ? 32'h1E0 : m ? 32'hE0 : 32'h20);
      bus(1'b1, 12'h000, 32'h1);
      repeat (20) @(posedge pclk);
      bus(1'b0, 12'h00C, 32'h0);
      chk("armed", rdat[1:0], m == 2 ? 2'h1 : 2'h2);
      @(posedge pclk);
      if (m) fpp <= 1'b1; else lp <= 1'b1;
      @(posedge pclk);
      fpp <= 1'b0;
      lp <= 1'b0;
      waitrun(1'b1);
      bus(1'b1, 12'h000, 32'h2);
    end
    $display("test start sync done");
    end_of_test;
  end
endmodule

bind rcw_run_ctrl rcw_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .evt(evt), .live_in(live_in), .gate_pin(gate_pin),
  .trig_line_in(trig_line_in), .trig_line_out(trig_line_out), .trig_line_oe(trig_line_oe),
  .fp_sync_in(fp_sync_in), .fp_sync_out(fp_sync_out), .fp_sync_oe(fp_sync_oe),
  .acq_enable(acq_enable), .spectrum_clear(spectrum_clear), .run_active(run_active));
`default_nettype wire
